// ===== rtl/dpg_consts.vh
// Constants for the PLL, gain and offset register bank.
// Included by the register bank; holds definitions only.
`ifndef DPG_CONSTS_VH
`define DPG_CONSTS_VH

// Register offsets within the 5-bit serial address space.
`define DPG_ADDR_DIVIDER 5'h03
`define DPG_ADDR_PLL_CP 5'h04
`define DPG_ADDR_I_FINE 5'h05
`define DPG_ADDR_I_COARSE 5'h06
`define DPG_ADDR_I_OFS_HI 5'h07
`define DPG_ADDR_I_OFS_LO 5'h08
`define DPG_ADDR_Q_FINE 5'h09
`define DPG_ADDR_Q_COARSE 5'h0a
`define DPG_ADDR_Q_OFS_HI 5'h0b
`define DPG_ADDR_Q_OFS_LO 5'h0c

// Field positions.
`define DPG_BIT_PLL_EN 7
`define DPG_BIT_CP_MANUAL 6
`define DPG_BIT_OFS_DIR 7
`define DPG_BIT_SPORT_BIDIR 7

// Reset values.
`define DPG_RST_BYTE 8'h00

// Serial instruction byte fields.
`define DPG_INSTR_RW 7
`define DPG_PHASE_BITS 4'h8

`endif

// ===== rtl/dpg_regs.v
// Configuration register bank for a dual I/Q DAC: PLL control, charge-pump bias,
// per-channel fine and coarse gain and offset with direction, behind a serial port.
// Assumes serial clock, chip select and data pins arrive asynchronously; they are
// synchronised to i_clk, which must run well above the serial clock rate.
`timescale 1ns/100ps
`default_nettype none
`include "dpg_consts.vh"

module dpg_regs (
	// Clock and reset
	input wire i_clk,
	input wire i_rst,
	// Serial control port pins
	input wire i_sclk,
	input wire i_cs_n,
	input wire i_sdio,
	output reg o_sdio,
	output reg o_sdio_oe_n,
	output reg o_serial_data_out_pin,
	output reg o_serial_data_out_pin_oe_n,
	// Port configuration
	input wire i_sport_bidir,
	// PLL and clock divider controls
	output wire o_pll_en,
	output wire [1:0] o_clk_div_log2,
	output wire [3:0] o_clk_div_ratio,
	output reg [9:0] o_cp_bias_ua,
	// I channel scaling and offset
	output wire [7:0] o_i_fine_gain,
	output wire [3:0] o_i_coarse_gain,
	output wire [9:0] o_i_offset,
	output wire o_i_offset_to_output_current_b,
	// Q channel scaling and offset
	output wire [7:0] o_q_fine_gain,
	output wire [3:0] o_q_coarse_gain,
	output wire [9:0] o_q_offset,
	output wire o_q_offset_to_output_current_b
);

	localparam ST_INSTR = 1'b0;
	localparam ST_DATA = 1'b1;

	// Divider register holds only its two ratio bits; the rest read as zero.
	reg [1:0] div_q;
	reg [7:0] pll_q;
	reg [7:0] i_fine_q, i_coarse_q, i_ofs_hi_q, i_ofs_lo_q;
	reg [7:0] q_fine_q, q_coarse_q, q_ofs_hi_q, q_ofs_lo_q;

	// Two-flop synchronisers; the second stage feeds logic, and sclk's third stage also feeds edge detection.
	reg [2:0] sclk_q, cs_q, sdi_q;
	reg [1:0] bidir_q;
	wire sclk_s = sclk_q[1];
	wire cs_s = cs_q[1];
	wire sdi_s = sdi_q[1];
	// Port mode is a pin level, so it is synchronised like the serial pins.
	wire bidir_s = bidir_q[1];
	wire sclk_rise = sclk_s & ~sclk_q[2];
	wire sclk_fall = ~sclk_s & sclk_q[2];

	reg state_q;
	reg [3:0] bitcnt_q;
	reg [7:0] sh_q;
	reg rd_q;
	reg [1:0] nleft_q;
	reg [4:0] addr_q;
	reg [7:0] tx_q;

	// Register read mux, used at every byte boundary of a read.
	function [7:0] rd_byte;
		input [4:0] a;
		begin
			if (a == `DPG_ADDR_DIVIDER) rd_byte = {6'h00, div_q};
			else if (a == `DPG_ADDR_PLL_CP) rd_byte = pll_q;
			else if (a == `DPG_ADDR_I_FINE) rd_byte = i_fine_q;
			else if (a == `DPG_ADDR_I_COARSE) rd_byte = i_coarse_q;
			else if (a == `DPG_ADDR_I_OFS_HI) rd_byte = i_ofs_hi_q;
			else if (a == `DPG_ADDR_I_OFS_LO) rd_byte = i_ofs_lo_q;
			else if (a == `DPG_ADDR_Q_FINE) rd_byte = q_fine_q;
			else if (a == `DPG_ADDR_Q_COARSE) rd_byte = q_coarse_q;
			else if (a == `DPG_ADDR_Q_OFS_HI) rd_byte = q_ofs_hi_q;
			else if (a == `DPG_ADDR_Q_OFS_LO) rd_byte = q_ofs_lo_q;
			else rd_byte = 8'h00;
		end
	endfunction

	wire [7:0] sh_next = {sh_q[6:0], sdi_s};
	wire byte_done = sclk_rise & (bitcnt_q == 4'h7);

	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			sclk_q <= 3'h0;
			cs_q <= 3'h7;
			sdi_q <= 3'h0;
			bidir_q <= 2'h0;
		end else begin
			sclk_q <= {sclk_q[1:0], i_sclk};
			cs_q <= {cs_q[1:0], i_cs_n};
			sdi_q <= {sdi_q[1:0], i_sdio};
			bidir_q <= {bidir_q[0], i_sport_bidir};
		end
	end

	// Serial engine: MSB first, instruction then 1 to 4 data bytes, address decrementing.
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state_q <= ST_INSTR;
			bitcnt_q <= 4'h0;
			sh_q <= `DPG_RST_BYTE;
			rd_q <= 1'b0;
			nleft_q <= 2'h0;
			addr_q <= 5'h00;
			tx_q <= `DPG_RST_BYTE;
			div_q <= 2'h0;
			pll_q <= `DPG_RST_BYTE;
			i_fine_q <= `DPG_RST_BYTE;
			i_coarse_q <= `DPG_RST_BYTE;
			i_ofs_hi_q <= `DPG_RST_BYTE;
			i_ofs_lo_q <= `DPG_RST_BYTE;
			q_fine_q <= `DPG_RST_BYTE;
			q_coarse_q <= `DPG_RST_BYTE;
			q_ofs_hi_q <= `DPG_RST_BYTE;
			q_ofs_lo_q <= `DPG_RST_BYTE;
		end else if (cs_s) begin
			// Deselect abandons any partial byte, so nothing half-shifted is written.
			state_q <= ST_INSTR;
			bitcnt_q <= 4'h0;
		end else if (sclk_rise) begin
			sh_q <= sh_next;
			bitcnt_q <= byte_done ? 4'h0 : bitcnt_q + 4'h1;
			if (byte_done) begin
				case (state_q)
				ST_INSTR: begin
					state_q <= ST_DATA;
					rd_q <= sh_next[`DPG_INSTR_RW];
					nleft_q <= sh_next[6:5];
					addr_q <= sh_next[4:0];
					tx_q <= rd_byte(sh_next[4:0]);
				end
				default: begin
					if (!rd_q) begin
						// Each byte lands on the last bit of its transfer.
						if (addr_q == `DPG_ADDR_DIVIDER) div_q <= sh_next[1:0];
						else if (addr_q == `DPG_ADDR_PLL_CP) pll_q <= sh_next;
						else if (addr_q == `DPG_ADDR_I_FINE) i_fine_q <= sh_next;
						else if (addr_q == `DPG_ADDR_I_COARSE) i_coarse_q <= sh_next;
						else if (addr_q == `DPG_ADDR_I_OFS_HI) i_ofs_hi_q <= sh_next;
						else if (addr_q == `DPG_ADDR_I_OFS_LO) i_ofs_lo_q <= sh_next;
						else if (addr_q == `DPG_ADDR_Q_FINE) q_fine_q <= sh_next;
						else if (addr_q == `DPG_ADDR_Q_COARSE) q_coarse_q <= sh_next;
						else if (addr_q == `DPG_ADDR_Q_OFS_HI) q_ofs_hi_q <= sh_next;
						else if (addr_q == `DPG_ADDR_Q_OFS_LO) q_ofs_lo_q <= sh_next;
					end
					addr_q <= addr_q - 5'h01;
					tx_q <= rd_byte(addr_q - 5'h01);
					nleft_q <= nleft_q - 2'h1;
					if (nleft_q == 2'h0) begin
						state_q <= ST_INSTR;
					end
				end
				endcase
			end
		end else if (sclk_fall && state_q == ST_DATA && bitcnt_q != 4'h0) begin
			tx_q <= {tx_q[6:0], 1'b0};
		end
	end

	// Read bits shift out after falling edges, each byte's first bit after the rising edge ending the prior byte; both pins float while deselected.
	wire rd_drive = ~cs_s & (state_q == ST_DATA) & rd_q;
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_sdio <= 1'b0;
			o_sdio_oe_n <= 1'b1;
			o_serial_data_out_pin <= 1'b0;
			o_serial_data_out_pin_oe_n <= 1'b1;
		end else begin
			o_sdio <= tx_q[7];
			o_serial_data_out_pin <= tx_q[7];
			o_sdio_oe_n <= ~(rd_drive & bidir_s);
			o_serial_data_out_pin_oe_n <= ~(rd_drive & ~bidir_s);
		end
	end

	// Divide ratio decode.
	function [3:0] div_ratio;
		input [1:0] code;
		begin
			div_ratio = 4'h1 << code;
		end
	endfunction

	// Manual bias decode; codes above 100 are undefined and give the largest bias.
	function [9:0] bias_ua;
		input [2:0] code;
		begin
			case (code)
			3'h0: bias_ua = 10'h032;
			3'h1: bias_ua = 10'h064;
			3'h2: bias_ua = 10'h0c8;
			3'h3: bias_ua = 10'h190;
			default: bias_ua = 10'h320;
			endcase
		end
	endfunction

	assign o_pll_en = pll_q[`DPG_BIT_PLL_EN];
	assign o_clk_div_log2 = div_q;
	assign o_clk_div_ratio = div_ratio(div_q);

	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_cp_bias_ua <= 10'h032;
		end else if (pll_q[`DPG_BIT_CP_MANUAL]) begin
			o_cp_bias_ua <= bias_ua(pll_q[2:0]);
		end else begin
			// Automatic mode scales bias with the divide ratio.
			o_cp_bias_ua <= bias_ua({1'b0, div_q});
		end
	end

	assign o_i_fine_gain = i_fine_q;
	assign o_i_coarse_gain = i_coarse_q[3:0];
	assign o_i_offset = {i_ofs_hi_q, i_ofs_lo_q[1:0]};
	assign o_i_offset_to_output_current_b = i_ofs_lo_q[`DPG_BIT_OFS_DIR];
	assign o_q_fine_gain = q_fine_q;
	assign o_q_coarse_gain = q_coarse_q[3:0];
	assign o_q_offset = {q_ofs_hi_q, q_ofs_lo_q[1:0]};
	assign o_q_offset_to_output_current_b = q_ofs_lo_q[`DPG_BIT_OFS_DIR];

endmodule // dpg_regs
`default_nettype wire

// ===== tb/dpg_regs_props.sv
// Port checker for the PLL, gain and offset register bank.
// Assumes reset is asynchronous, active high, and one clock domain.
`timescale 1ns/100ps
`default_nettype none
module dpg_regs_props (
	// Clock and reset
	input wire i_clk,
	input wire i_rst,
	// Watched ports
	input wire i_cs_n,
	input wire i_sport_bidir,
	input wire o_sdio_oe_n,
	input wire o_serial_data_out_pin_oe_n,
	input wire o_pll_en,
	input wire [1:0] o_clk_div_log2,
	input wire [3:0] o_clk_div_ratio,
	input wire [9:0] o_cp_bias_ua,
	input wire [7:0] o_i_fine_gain,
	input wire [9:0] o_i_offset,
	input wire [7:0] o_q_fine_gain,
	input wire [9:0] o_q_offset
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	a_reset_vals: assert property ($fell(i_rst) |-> !o_pll_en && o_cp_bias_ua == 10'h032)
		else $error("reset outputs wrong");
	a_div_decode: assert property (o_clk_div_ratio == (4'h1 << o_clk_div_log2))
		else $error("divider decode wrong");
	a_bias_legal: assert property (o_cp_bias_ua inside {10'h032, 10'h064, 10'h0c8, 10'h190, 10'h320})
		else $error("bias value illegal");
	a_oe_exclusive: assert property (o_sdio_oe_n || o_serial_data_out_pin_oe_n)
		else $error("both data pins driven");
	a_idle_hiz: assert property (i_cs_n [*6] |-> o_sdio_oe_n && o_serial_data_out_pin_oe_n)
		else $error("pin driven while deselected");
	a_mode_pin: assert property (i_sport_bidir ? o_serial_data_out_pin_oe_n : o_sdio_oe_n)
		else $error("wrong pin driven for mode");
	a_hold_i: assert property (i_cs_n [*8] |=> $stable({o_i_fine_gain, o_i_offset}))
		else $error("I codes moved while idle");
	a_hold_q: assert property (i_cs_n [*8] |=> $stable({o_q_fine_gain, o_q_offset}))
		else $error("Q codes moved while idle");
	a_hold_pll: assert property (i_cs_n [*8] |=> $stable({o_pll_en, o_cp_bias_ua}))
		else $error("PLL controls moved while idle");
endmodule // dpg_regs_props
bind dpg_regs dpg_regs_props i_props (.i_clk, .i_rst, .i_cs_n, .i_sport_bidir, .o_sdio_oe_n,
	.o_serial_data_out_pin_oe_n, .o_pll_en, .o_clk_div_log2, .o_clk_div_ratio, .o_cp_bias_ua,
	.o_i_fine_gain, .o_i_offset, .o_q_fine_gain, .o_q_offset);
`default_nettype wire

// ===== tb/dpg_host.sv
// Host model: serial transfers of one to three data bytes, MSB first, sclk idle low; a four-byte call never returns.
// Assumes i_clk runs sixteen times the serial clock or more.
`timescale 1ns/100ps
`default_nettype none
module dpg_host (
	// Clock
	input wire logic i_clk,
	// Serial pins
	output var logic o_sclk,
	output var logic o_cs_n,
	output wire logic o_sdio,
	input wire logic i_sdio,
	input wire logic i_sdio_oe_n,
	input wire logic i_sdo,
	input wire logic i_sdo_oe_n,
	input wire logic i_bidir
);
	logic h = 1'b0;
	initial o_sclk = 1'b0;
	initial o_cs_n = 1'b1;
	// A released line toggles each bit so a stale value never passes as data.
	assign o_sdio = i_sdio_oe_n ? h : i_sdio;
	// Data bytes go out from d[31:24] downwards; n is the byte count less one.
	task automatic xfer_n(input logic rd, input logic [1:0] n, input logic [4:0] a,
		input logic [31:0] d, output logic [31:0] q);
		logic [39:0] w;
		w = {rd, n, a, d};
		q = 32'h0000_0000;
		o_cs_n = 1'b0;
		repeat (4) @(negedge i_clk);
		for (int k = 39; k >= 32 - 8 * (n + 1); k--) begin
			o_sclk = 1'b0;
			h = (rd && k < 32) ? ~h : w[k];
			repeat (8) @(negedge i_clk);
			// An undriven pin reads as the inverse, so a missing enable shows up.
			if (k < 32)
				q[k] = i_bidir ? (i_sdio_oe_n ? ~i_sdio : i_sdio)
					: (i_sdo_oe_n ? ~i_sdo : i_sdo);
			o_sclk = 1'b1;
			repeat (8) @(negedge i_clk);
		end
		o_sclk = 1'b0;
		o_cs_n = 1'b1;
		repeat (8) @(negedge i_clk);
	endtask
	task automatic xfer(input logic rd, input logic [4:0] a, input logic [7:0] d,
		output logic [7:0] q);
		logic [31:0] r;
		xfer_n(rd, 2'b00, a, {d, 24'h00_0000}, r);
		q = r[31:24];
	endtask
endmodule // dpg_host
`default_nettype wire

// ===== tb/dpg_regs_bench.sv
// Bench for the register bank: writes, reads back and checks decoded outputs.
// Uses dpg_host for all serial traffic; inputs change on falling edges.
`timescale 1ns/100ps
`default_nettype none
module dpg_regs_bench;
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	logic i_sport_bidir = 1'b0;
	wire i_sclk, i_cs_n, i_sdio, o_sdio, o_sdio_oe_n, o_serial_data_out_pin, o_pll_en;
	wire o_serial_data_out_pin_oe_n, o_i_offset_to_output_current_b, o_q_offset_to_output_current_b;
	wire [1:0] o_clk_div_log2;
	wire [3:0] o_clk_div_ratio, o_i_coarse_gain, o_q_coarse_gain;
	wire [7:0] o_i_fine_gain, o_q_fine_gain;
	wire [9:0] o_cp_bias_ua, o_i_offset, o_q_offset;
	integer n_fail = 0;
	integer checked = 0;
	logic [7:0] q;
	logic [31:0] r;
	logic [7:0] v [0:15];
	initial forever #2 i_clk = ~i_clk;
	dpg_regs i_dut (.i_clk, .i_rst, .i_sclk, .i_cs_n, .i_sdio, .o_sdio, .o_sdio_oe_n,
		.o_serial_data_out_pin, .o_serial_data_out_pin_oe_n, .i_sport_bidir, .o_pll_en,
		.o_clk_div_log2, .o_clk_div_ratio, .o_cp_bias_ua, .o_i_fine_gain, .o_i_coarse_gain,
		.o_i_offset, .o_i_offset_to_output_current_b, .o_q_fine_gain, .o_q_coarse_gain,
		.o_q_offset, .o_q_offset_to_output_current_b);
	dpg_host i_host (.i_clk(i_clk), .o_sclk(i_sclk), .o_cs_n(i_cs_n), .o_sdio(i_sdio),
		.i_sdio(o_sdio), .i_sdio_oe_n(o_sdio_oe_n), .i_sdo(o_serial_data_out_pin),
		.i_sdo_oe_n(o_serial_data_out_pin_oe_n), .i_bidir(i_sport_bidir));
	task automatic chk(input string s, input logic [9:0] g, input logic [9:0] e);
		checked++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value %s exp %h got %h", s, e, g);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		#100000;
		n_fail++;
		tally_and_finish;
	end
	initial begin
		repeat (10) @(negedge i_clk);
		i_rst = 1'b0;
		repeat (4) @(negedge i_clk);
		chk("pll", o_pll_en, 10'h000);
		chk("bias", o_cp_bias_ua, 10'h032);
		for (int k = 5; k < 13; k++) begin
			v[k] = 8'h3c ^ (k[7:0] * 8'h27);
			i_host.xfer(1'b0, k[4:0], v[k], q);
		end
		for (int k = 5; k < 13; k++) begin
			i_host.xfer(1'b1, k[4:0], 8'h00, q);
			chk("readback", q, v[k]);
		end
		chk("i fine", o_i_fine_gain, v[5]);
		chk("q fine", o_q_fine_gain, v[9]);
		chk("i coarse", o_i_coarse_gain, v[6][3:0]);
		chk("q coarse", o_q_coarse_gain, v[10][3:0]);
		chk("i offset", o_i_offset, {v[7], v[8][1:0]});
		chk("q offset", o_q_offset, {v[11], v[12][1:0]});
		chk("i dir", o_i_offset_to_output_current_b, v[8][7]);
		chk("q dir", o_q_offset_to_output_current_b, v[12][7]);
		$display("test gain offset done");
		for (int k = 0; k < 4; k++) begin
			i_host.xfer(1'b0, 5'h03, k[7:0], q);
			chk("div", o_clk_div_ratio, 10'h001 << k);
			chk("div code", o_clk_div_log2, k[1:0]);
			chk("auto bias", o_cp_bias_ua, 10'h032 << k);
		end
		for (int k = 0; k < 5; k++) begin
			i_host.xfer(1'b0, 5'h04, 8'hc0 | k[7:0], q);
			chk("pll", o_pll_en, 10'h001);
			chk("manual bias", o_cp_bias_ua, 10'h032 << k);
		end
		i_host.xfer(1'b0, 5'h04, 8'h00, q);
		chk("pll", o_pll_en, 10'h000);
		chk("auto bias", o_cp_bias_ua, 10'h190);
		i_host.xfer(1'b1, 5'h1f, 8'h00, q);
		chk("unmapped", q, 10'h000);
		$display("test pll done");
		i_host.xfer_n(1'b0, 2'h1, 5'h0c, 32'h815a_0000, r);
		chk("burst offset", o_q_offset, 10'h169);
		chk("burst dir", o_q_offset_to_output_current_b, 10'h001);
		i_host.xfer_n(1'b1, 2'h1, 5'h0c, 32'h0000_0000, r);
		chk("burst lo", r[31:24], 10'h081);
		chk("burst hi", r[23:16], 10'h05a);
		$display("test burst done");
		i_sport_bidir = 1'b1;
		i_host.xfer(1'b1, 5'h09, 8'h00, q);
		chk("bidir read", q, v[9]);
		$display("test bidir done");
		tally_and_finish;
	end
endmodule // dpg_regs_bench
`default_nettype wire
